// ---- scmp_clkgen.sv ----
// serial clock source selection, baud generator and clock pin driver
`timescale 1ns/100ps
module scmp_clkgen
   import scmp_pkg::*;
(
   // clock and reset
   input  wire logic      aclk,
   input  wire logic      aresetn,
   // configuration
   input  wire scmp_src_t src,
   input  wire logic      sync,
   input  wire logic [7:0] div,
   // serial clock pin
   input  wire logic      pin_i,
   output logic           pin_o,
   output logic           pin_oe,
   // ticks to the rest of the unit
   output logic           tick16,
   output logic           bit_tick
);

   logic [7:0] div_cnt_r;
   logic [3:0] ph_r;
   logic       pin_q_r;
   logic       brg_tick;
   logic       ext_rise;
   logic       tick_src;

   assign brg_tick = (div_cnt_r == div);
   assign ext_rise = pin_i & ~pin_q_r;
   assign tick_src = (src == SRC_EXT) ? ext_rise :
                     (src == SRC_NONE) ? 1'b0 : brg_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) div_cnt_r <= 8'h00;
      else if (brg_tick) div_cnt_r <= 8'h00;
      else div_cnt_r <= div_cnt_r + 8'h01;
   end

   // pin sampled once for edge detection only
   always_ff @(posedge aclk) begin
      if (!aresetn) pin_q_r <= 1'b0;
      else pin_q_r <= pin_i;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) ph_r <= 4'h0;
      else if (tick_src) ph_r <= ph_r + 4'h1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick16   <= 1'b0;
         bit_tick <= 1'b0;
      end else begin
         tick16 <= ~sync & tick_src;
         if (sync && src == SRC_EXT) bit_tick <= ext_rise;
         else bit_tick <= tick_src && ph_r == PH_LAST;
      end
   end

   // pin drives only for an internal clock with output selected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_oe <= 1'b0;
         pin_o  <= 1'b0;
      end else begin
         pin_oe <= (src == SRC_BRG_OUT);
         pin_o  <= ph_r[3];
      end
   end

   ext_in_a: assert property (@(posedge aclk) disable iff (!aresetn)
      src == SRC_EXT |=> !pin_oe)
      else $error("pin driven while external clock selected");
   brg_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
      src == SRC_BRG_OUT |=> pin_oe)
      else $error("clock output not driven");
   brg_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
      src == SRC_BRG |=> !pin_oe)
      else $error("pin driven for plain internal clock");
   mid_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pin_o) |-> $past(ph_r) == PH_MID)
      else $error("output clock edge not at mid bit");
   ext_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (src == SRC_EXT && !sync && ext_rise) |=> tick16)
      else $error("external edge gave no sample tick");
   sync_ext_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (src == SRC_EXT && sync && ext_rise) |=> bit_tick)
      else $error("synchronous external edge gave no bit tick");
   cv_clk_out_c: cover property (@(posedge aclk) disable iff (!aresetn)
      pin_oe && $rose(pin_o));

endmodule

// ---- scmp_pkg.sv ----
// constants, types and clock source decode for the serial control block
package scmp_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MODE   = 8'h04;
   localparam logic [7:0] OFS_STAT   = 8'h08;
   localparam logic [7:0] OFS_RXDATA = 8'h0c;
   localparam logic [7:0] OFS_IRQST  = 8'h10;
   localparam logic [7:0] OFS_IRQEN  = 8'h14;
   localparam logic [7:0] OFS_IRQCLR = 8'h18;
   localparam logic [7:0] OFS_DIV    = 8'h1c;

   // serial_control_reg fields
   localparam int CTRL_FILT   = 3;
   localparam int CTRL_TXEND  = 2;
   localparam int CTRL_CKE_HI = 1;
   localparam int CTRL_CKE_LO = 0;
   // mode register fields
   localparam int MODE_SYNC   = 0;
   localparam int MODE_MULTI  = 1;
   // status register fields
   localparam int ST_RX_FULL  = 0;
   localparam int ST_FRAMING  = 1;
   localparam int ST_OVERRUN  = 2;
   localparam int ST_MPB      = 3;
   // interrupt status, enable and clear fields
   localparam int IRQ_W       = 4;
   localparam int IRQ_RX      = 0;
   localparam int IRQ_ERR     = 1;
   localparam int IRQ_ID      = 2;
   localparam int IRQ_TXEND   = 3;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [7:0] DIV_RST  = 8'h03;

   // bit-rate clock phase: rising output edge at the middle of a bit
   localparam logic [3:0] PH_MID  = 4'h8;
   localparam logic [3:0] PH_LAST = 4'hf;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SRC_BRG, SRC_BRG_OUT, SRC_EXT, SRC_NONE}
      scmp_src_t;

   // one received frame as reported by the receiver
   typedef struct packed {
      logic       valid;
      logic       mpb;
      logic       ferr;
      logic [7:0] data;
   } scmp_frame_t;

   function automatic scmp_src_t clk_src(input logic [1:0] code,
                                         input logic sync);
      if (sync) begin
         if (code == 2'h0) clk_src = SRC_BRG_OUT;
         else if (code == 2'h2) clk_src = SRC_EXT;
         else clk_src = SRC_NONE;
      end else begin
         if (code == 2'h0) clk_src = SRC_BRG;
         else if (code == 2'h1) clk_src = SRC_BRG_OUT;
         else if (code == 2'h2) clk_src = SRC_EXT;
         else clk_src = SRC_NONE;
      end
   endfunction

endpackage

// ---- scmp_remote_node.sv ----
// remote serial node: received frames and external serial clock
`timescale 1ns/100ps
module scmp_remote_node
   import scmp_pkg::*;
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // requests from the bench
   input  wire logic       send,
   input  wire logic       mpb,
   input  wire logic       bad,
   input  wire logic [7:0] data,
   input  wire logic       ext_en,
   // towards the unit
   output scmp_frame_t     frame,
   output logic            ext_clk
);
   logic [1:0] cnt_r;

   // idle data shows the inverse so stale bytes never look valid
   always_ff @(posedge aclk) begin
      if (!aresetn)
         frame <= '0;
      else
         frame <= '{send, mpb, bad, send ? data : ~frame.data};
   end

   // 16x clock, period 4 aclk; stands low when unused
   always_ff @(posedge aclk) begin
      if (!aresetn || !ext_en) begin
         cnt_r   <= 2'h0;
         ext_clk <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
         if (cnt_r[0])
            ext_clk <= ~ext_clk;
      end
   end
endmodule

// ---- scmp_serial_ctrl.sv ----
// serial control: clock select, tx end irq, multiprocessor filter
//
// Summary of operation
// - filter on: drop id-bit-0 frames, no flags
// - id-bit-1 frame clears filter, resumes reception
// - filter works only in async multiproc mode
// - tx end irq passes only when enabled
// - async 00/01 internal; 01 drives pin clock
// - async 10 takes 16x clock from pin
// - sync 00 drives clock, 10 pin input
// - frame: start low, lsb first, stops high
// - output clock rises mid transmitted bit
`timescale 1ns/100ps
module scmp_serial_ctrl
   import scmp_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // receiver and transmitter of the unit
   input  wire scmp_frame_t frame,
   input  wire logic        tx_end_level,
   output logic             rx_full_flag,
   output logic             framing_error_flag,
   output logic             overrun_error_flag,
   output logic             multiproc_mode,
   output logic             tx_end_irq,
   output logic             irq,
   // serial clock
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe,
   output logic             tick16,
   output logic             bit_tick
);

   logic [7:0]       serial_control_r;
   logic [1:0]       mode_r;
   logic [7:0]       div_r;
   logic [7:0]       rx_data_r;
   logic             mpb_r;
   logic [IRQ_W-1:0] irq_st_r;
   logic [IRQ_W-1:0] irq_en_r;
   logic [IRQ_W-1:0] irq_st_nxt;
   logic [IRQ_W-1:0] irq_en_nxt;
   logic             tx_end_q_r;
   logic             aw_held_r;
   logic             w_held_r;
   logic [7:0]       aw_addr_r;
   logic [7:0]       w_data_r;
   logic             w_lane_r;
   logic             wr_fire;
   logic             wr_en;
   logic             wr_ctrl;
   logic             wr_stat;
   logic [7:0]       stat_clr;
   logic             filter_on;
   logic             accept;
   logic             id_hit;
   logic             overrun;
   logic             txend_ev;
   logic [IRQ_W-1:0] irq_ev;
   logic [IRQ_W-1:0] irq_clr;
   scmp_src_t        src;

   function automatic logic addr_mapped(input logic [7:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      if (w == OFS_CTRL) addr_mapped = 1'b1;
      else if (w == OFS_MODE) addr_mapped = 1'b1;
      else if (w == OFS_STAT) addr_mapped = 1'b1;
      else if (w == OFS_RXDATA) addr_mapped = 1'b1;
      else if (w == OFS_IRQST) addr_mapped = 1'b1;
      else if (w == OFS_IRQEN) addr_mapped = 1'b1;
      else if (w == OFS_IRQCLR) addr_mapped = 1'b1;
      else if (w == OFS_DIV) addr_mapped = 1'b1;
      else addr_mapped = 1'b0;
   endfunction

   // ---------------- write channel ----------------
   // address and data are held separately so either may come first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b0;
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (awvalid && awready) begin
         awready   <= 1'b0;
         aw_held_r <= 1'b1;
         aw_addr_r <= {awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end else if (!aw_held_r && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready   <= 1'b0;
         w_held_r <= 1'b0;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
      end else if (wvalid && wready) begin
         wready   <= 1'b0;
         w_held_r <= 1'b1;
         w_data_r <= wdata[7:0];
         w_lane_r <= wstrb[0];
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end else if (!w_held_r && !bvalid) begin
         wready <= 1'b1;
      end
   end

   assign wr_fire = aw_held_r & w_held_r & ~bvalid;
   assign wr_en   = wr_fire & w_lane_r;
   assign wr_ctrl = wr_en && aw_addr_r == OFS_CTRL;
   assign wr_stat = wr_en && aw_addr_r == OFS_STAT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---------------- read channel ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         if ({araddr[7:2], 2'b00} == OFS_CTRL)
            rdata <= {24'h0, serial_control_r};
         else if ({araddr[7:2], 2'b00} == OFS_MODE)
            rdata <= {30'h0, mode_r};
         else if ({araddr[7:2], 2'b00} == OFS_STAT)
            rdata <= {28'h0, mpb_r, overrun_error_flag,
                      framing_error_flag, rx_full_flag};
         else if ({araddr[7:2], 2'b00} == OFS_RXDATA)
            rdata <= {24'h0, rx_data_r};
         else if ({araddr[7:2], 2'b00} == OFS_IRQST)
            rdata <= {28'h0, irq_st_r};
         else if ({araddr[7:2], 2'b00} == OFS_IRQEN)
            rdata <= {28'h0, irq_en_r};
         else if ({araddr[7:2], 2'b00} == OFS_DIV)
            rdata <= {24'h0, div_r};
         else
            rdata <= 32'h0000_0000;
      end else if (rvalid) begin
         if (rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end else begin
         arready <= 1'b1;
      end
   end

   // ---------------- configuration ----------------
   // a software write in the same cycle as an id frame wins over
   // the hardware clear, so a fresh enable is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn) serial_control_r <= CTRL_RST;
      else if (wr_ctrl) serial_control_r <= {4'h0, w_data_r[3:0]};
      else if (id_hit) serial_control_r[CTRL_FILT] <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) mode_r <= MODE_RST;
      else if (wr_en && aw_addr_r == OFS_MODE) mode_r <= w_data_r[1:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) div_r <= DIV_RST;
      else if (wr_en && aw_addr_r == OFS_DIV) div_r <= w_data_r;
   end

   assign multiproc_mode = mode_r[MODE_MULTI];

   // reserved codes stop the clock rather than guess a source
   assign src = clk_src({serial_control_r[CTRL_CKE_HI],
                         serial_control_r[CTRL_CKE_LO]},
                        mode_r[MODE_SYNC]);

   scmp_clkgen u_clkgen (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .src      (src),
      .sync     (mode_r[MODE_SYNC]),
      .div      (div_r),
      .pin_i    (serial_clock_pin_i),
      .pin_o    (serial_clock_pin_o),
      .pin_oe   (serial_clock_pin_oe),
      .tick16   (tick16),
      .bit_tick (bit_tick)
   );

   // ---------------- multiprocessor filter ----------------
   // the frame itself (start, lsb first, stops) is decoded upstream
   assign filter_on = serial_control_r[CTRL_FILT] & mode_r[MODE_MULTI]
                      & ~mode_r[MODE_SYNC];
   assign accept  = frame.valid & ~(filter_on & ~frame.mpb);
   assign id_hit  = frame.valid & filter_on & frame.mpb;
   assign stat_clr = wr_stat ? w_data_r : 8'h00;
   assign overrun = accept & rx_full_flag & ~stat_clr[ST_RX_FULL];

   // flags set by hardware win over a same-cycle write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_full_flag       <= 1'b0;
         framing_error_flag <= 1'b0;
         overrun_error_flag <= 1'b0;
      end else begin
         rx_full_flag <= accept |
                         (rx_full_flag & ~stat_clr[ST_RX_FULL]);
         framing_error_flag <= (accept & frame.ferr) |
            (framing_error_flag & ~stat_clr[ST_FRAMING]);
         overrun_error_flag <= overrun |
            (overrun_error_flag & ~stat_clr[ST_OVERRUN]);
      end
   end

   // on overrun the unread byte is kept and the new one is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data_r <= 8'h00;
         mpb_r     <= 1'b0;
      end else if (accept && !overrun) begin
         rx_data_r <= frame.data;
         mpb_r     <= frame.mpb;
      end
   end

   // ---------------- interrupts ----------------
   assign txend_ev = tx_end_level & ~tx_end_q_r
                     & serial_control_r[CTRL_TXEND];
   assign irq_clr  = (wr_en && aw_addr_r == OFS_IRQCLR) ?
                     w_data_r[IRQ_W-1:0] : {IRQ_W{1'b0}};

   always_comb begin
      irq_ev             = {IRQ_W{1'b0}};
      irq_ev[IRQ_RX]     = accept & ~overrun;
      irq_ev[IRQ_ERR]    = overrun | (accept & frame.ferr);
      irq_ev[IRQ_ID]     = id_hit;
      irq_ev[IRQ_TXEND]  = txend_ev;
      irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
      irq_en_nxt = irq_en_r;
      if (wr_en && aw_addr_r == OFS_IRQEN)
         irq_en_nxt = w_data_r[IRQ_W-1:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_st_r <= {IRQ_W{1'b0}};
         irq_en_r <= {IRQ_W{1'b0}};
         irq      <= 1'b0;
      end else begin
         irq_st_r <= irq_st_nxt;
         irq_en_r <= irq_en_nxt;
         irq      <= |(irq_st_nxt & irq_en_nxt);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_end_q_r <= 1'b0;
         tx_end_irq <= 1'b0;
      end else begin
         tx_end_q_r <= tx_end_level;
         tx_end_irq <= tx_end_level & serial_control_r[CTRL_TXEND];
      end
   end

   // ---------------- checks ----------------
   filter_drop_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (filter_on && frame.valid && !frame.mpb && !rx_full_flag)
      |=> !rx_full_flag && !$rose(framing_error_flag) && $stable(rx_data_r))
      else $error("filtered frame changed receive state");
   filter_noerr_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (filter_on && frame.valid && !frame.mpb) |=> !$rose(overrun_error_flag))
      else $error("filtered frame raised overrun");
   id_clear_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (id_hit && !wr_ctrl) |=> !serial_control_r[CTRL_FILT] && rx_full_flag)
      else $error("id frame did not clear filter");
   no_filter_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (frame.valid && (mode_r[MODE_SYNC] || !mode_r[MODE_MULTI]))
      |=> rx_full_flag)
      else $error("frame dropped outside multiprocessor mode");
   txend_mask_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !serial_control_r[CTRL_TXEND] |=> !tx_end_irq)
      else $error("tx end irq not masked");
   txend_pass_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (serial_control_r[CTRL_TXEND] && tx_end_level) |=> tx_end_irq)
      else $error("tx end irq not raised");
   irq_level_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ##1 irq == |(irq_st_r & irq_en_r))
      else $error("irq does not match enabled status");
   bresp_hold_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (bvalid && !bready) |=> bvalid && $stable(bresp))
      else $error("write response dropped before ready");
   clk_pin_a: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (src == SRC_BRG_OUT)[*2] |-> serial_clock_pin_oe)
      else $error("selected clock output not driven");

   cv_discard_c: cover property (@(posedge aclk) disable iff (!aresetn)
      filter_on && frame.valid && !frame.mpb);
   cv_id_c: cover property (@(posedge aclk) disable iff (!aresetn)
      id_hit ##1 frame.valid);
   cv_txend_c: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(tx_end_irq));
   cv_overrun_c: cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(overrun_error_flag));

endmodule

// ---- scmp_serial_ctrl_tb.sv ----
// self-checking bench for the serial control block
`timescale 1ns/100ps
module scmp_serial_ctrl_tb
   import scmp_pkg::*;
;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, tx_end_level;
   logic [7:0]  awaddr, araddr, sdata;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   scmp_frame_t frame;
   logic        rxf, ferr, ovr, mpm, tx_end_irq, irq, pin_i, pin_o, pin_oe;
   logic        tick16, bit_tick, send, mpb, ext_en, ext_clk, sbad;
   int          miscompares, compares;

   // device drives the pin when enabled, else the remote clock
   assign pin_i = pin_oe ? pin_o : ext_clk;

   scmp_serial_ctrl uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .frame(frame), .tx_end_level(tx_end_level),
      .rx_full_flag(rxf), .framing_error_flag(ferr),
      .overrun_error_flag(ovr), .multiproc_mode(mpm),
      .tx_end_irq(tx_end_irq), .irq(irq), .serial_clock_pin_i(pin_i),
      .serial_clock_pin_o(pin_o), .serial_clock_pin_oe(pin_oe),
      .tick16(tick16), .bit_tick(bit_tick));

   scmp_remote_node node (.aclk(aclk), .aresetn(aresetn), .send(send),
      .mpb(mpb), .bad(sbad), .data(sdata), .ext_en(ext_en), .frame(frame),
      .ext_clk(ext_clk));

   initial aclk = 1'b0;
   always #50 aclk = ~aclk;

   task automatic chk(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            rs = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rd_reg(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rd = rdata;
            rs = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic frm(input logic b, input logic [7:0] d);
      @(posedge aclk);
      send  <= 1'b1;
      mpb   <= b;
      sdata <= d;
      @(posedge aclk);
      send <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   // cycles up to the next rising edge of the output clock
   task automatic wait_rise(output int k);
      logic p;
      p = pin_o;
      k = 0;
      while (k < 300 && !(pin_o === 1'b1 && p === 1'b0)) begin
         p = pin_o;
         @(posedge aclk);
         k++;
      end
   endtask

   task automatic t_regs;
      rd_reg(OFS_CTRL);
      chk(rd, {24'h0, CTRL_RST}, "control reset");
      rd_reg(OFS_DIV);
      chk(rd, {24'h0, DIV_RST}, "divisor reset");
      rd_reg(8'h20);
      chk(rd, 32'h0, "unmapped read data");
      chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read");
      wr(8'h24, 32'hff);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
   endtask

   task automatic t_txend;
      wr(OFS_IRQEN, 32'h8);
      tx_end_level <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({tx_end_irq, irq}, 2'b00, "tx end masked");
      tx_end_level <= 1'b0;
      wr(OFS_CTRL, 32'h4);
      tx_end_level <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({tx_end_irq, irq}, 2'b11, "tx end enabled");
      wr(OFS_IRQCLR, 32'h8);
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      chk({tx_end_irq, irq}, 2'b00, "tx end masked again");
   endtask

   task automatic t_filter;
      wr(OFS_MODE, 32'h2);
      chk({31'h0, mpm}, 32'h1, "multiproc mode out");
      wr(OFS_CTRL, 32'h8);
      // both frames carry a framing error: only the id frame may flag it
      sbad <= 1'b1;
      frm(1'b0, 8'h5a);
      chk({29'h0, rxf, ferr, ovr}, 32'h0, "filtered frame dropped");
      frm(1'b1, 8'h3c);
      sbad <= 1'b0;
      chk({30'h0, rxf, ferr}, 32'h3, "id frame accepted");
      rd_reg(OFS_CTRL);
      chk(rd[3:0], 4'h0, "filter cleared");
      rd_reg(OFS_RXDATA);
      chk(rd[7:0], 8'h3c, "id data");
      rd_reg(OFS_IRQST);
      chk(rd, 32'h7, "id frame events");
      frm(1'b0, 8'h11);
      chk(ovr, 1'b1, "reception resumed");
      wr(OFS_STAT, 32'h7);
      wr(OFS_MODE, 32'h3);
      wr(OFS_CTRL, 32'ha);
      frm(1'b0, 8'h22);
      chk(rxf, 1'b1, "no filter in sync mode");
      wr(OFS_STAT, 32'h7);
      wr(OFS_MODE, 32'h0);
      wr(OFS_CTRL, 32'h8);
      frm(1'b0, 8'h33);
      chk(rxf, 1'b1, "no filter without multiproc mode");
      wr(OFS_STAT, 32'h7);
   endtask

   task automatic t_clk;
      // sync, code, pin driven; reserved codes never written
      logic [3:0] tab [5] = '{4'b0000, 4'b0011, 4'b0100, 4'b1001, 4'b1100};
      int n, k;
      foreach (tab[i]) begin
         wr(OFS_CTRL, 32'h0);
         wr(OFS_MODE, {31'h0, tab[i][3]});
         ext_en <= (tab[i][2:1] == 2'h2);
         wr(OFS_CTRL, {30'h0, tab[i][2:1]});
         repeat (8) @(posedge aclk);
         chk(pin_oe, tab[i][0], "pin direction");
         n = 0;
         repeat (64) begin
            @(posedge aclk);
            n += tab[i][3] ? bit_tick : tick16;
         end
         if (tab[i] == 4'b1001)
            chk(n, 1, "sync bit rate");
         else
            chk(n >= 15 && n <= 17, 1'b1, "tick rate");
         if (tab[i] == 4'b0011) begin
            wait_rise(k);
            wait_rise(k);
            chk(k, 16 * (DIV_RST + 1), "output clock period");
         end
      end
      ext_en <= 1'b0;
   endtask

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {tx_end_level, send, mpb, ext_en, sbad, sdata, awaddr, araddr} = '0;
      wdata = '0;
      wstrb = 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_txend();
      t_filter();
      t_clk();
      end_of_test();
   end

   // whole run needs well under 5000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      end_of_test();
   end
endmodule
